// File: dv/mltc_modem_model.sv
// Modem partner: clear-to-send and dial answer for the line timing block
// Assumes: lags set by the bench, clk_sys shared with the design
`timescale 1ns/100ps

module mltc_modem_model
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       rts,
    input  wire logic [7:0] cts_lag,
    input  wire logic       dial_start,
    input  wire logic       ans_en,
    input  wire logic [7:0] ans_lag,
    output logic            cts_in,
    output logic            dial_answer
);
    logic [7:0] cts_cnt;
    logic [7:0] ans_cnt;
    logic       ringing;

    ////////////////////////////////////////
    // Clear-to-send follows request-to-send after a settable lag, drops with it
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cts_cnt <= 8'h00;
            cts_in  <= 1'h0;
        end
        else if (!rts)
        begin
            cts_cnt <= 8'h00;
            cts_in  <= 1'h0;
        end
        else if (cts_cnt >= cts_lag)
            cts_in <= 1'h1;
        else
            cts_cnt <= cts_cnt + 8'h01;
    end

    ////////////////////////////////////////
    // Far end answers once per attempt; never answers when disabled
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ringing     <= 1'h0;
            ans_cnt     <= 8'h00;
            dial_answer <= 1'h0;
        end
        else if (dial_start)
        begin
            ringing     <= 1'h1;
            ans_cnt     <= 8'h00;
            dial_answer <= 1'h0;
        end
        else if (ringing && ans_en && ans_cnt >= ans_lag)
        begin
            ringing     <= 1'h0;
            dial_answer <= 1'h1;
        end
        else
        begin
            ans_cnt     <= ans_cnt + 8'h01;
            dial_answer <= 1'h0;
        end
    end
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the line timing block
// Assumes: short tick parameters; modem model drives cts_in and dial_answer
`timescale 1ns/100ps
`include "mltc_map.svh"

module tb_top import mltc_pkg::*;;
    localparam int TT = 4;
    localparam int RT = 10;
    logic       clk_sys   = 1'h0;
    logic       reset     = 1'h1;
    logic       cfg_wr    = 1'h0;
    logic [2:0] cfg_idx   = 3'h0;
    logic [7:0] cfg_wdata = 8'h00;
    logic       two_w     = 1'h0;
    logic       cts_use   = 1'h0;
    logic       rts_req   = 1'h0;
    logic       ds_low    = 1'h0;
    logic       dial_go   = 1'h0;
    logic       ans_en    = 1'h0;
    logic [7:0] cts_lag   = 8'h00;
    logic [7:0] ans_lag   = 8'h05;
    logic [7:0] rdata;
    logic [7:0] param;
    logic       cts_in;
    logic       answer;
    logic       rts;
    logic       tx_en;
    logic       rx_smp;
    logic       rate_low;
    logic       disc;
    logic       lang;
    int         errors    = 0;
    int         cmp_count = 0;
    int         cycles    = 0;

    ////////////////////////////////////////
    // Design and modem partner
    mltc_line_timing #(.TURN_TICK_CYC(TT), .RING_TICK_CYC(RT)) DUT (
        .clk_sys(clk_sys), .reset(reset), .cfg_wr(cfg_wr), .cfg_idx(cfg_idx),
        .cfg_wdata(cfg_wdata), .cfg_rdata_ff(rdata), .line_two_wire(two_w),
        .cts_use(cts_use), .rts_req(rts_req), .cts_in(cts_in),
        .downstream_rate_low(ds_low), .dial_start(dial_go), .dial_answer(answer),
        .rts_ff(rts), .tx_enable_ff(tx_en), .rx_sample_ff(rx_smp),
        .line_rate_low_ff(rate_low), .dial_disconnect_ff(disc),
        .basic_vm_language_ff(lang), .proc_param_ff(param));
    mltc_modem_model MODEM (
        .clk_sys(clk_sys), .reset(reset), .rts(rts), .cts_lag(cts_lag),
        .dial_start(dial_go), .ans_en(ans_en), .ans_lag(ans_lag),
        .cts_in(cts_in), .dial_answer(answer));

    ////////////////////////////////////////
    // Clock and hang guard
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            errors++;
            summarize();
        end
    end

    task automatic summarize;
        if (errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h got %h", nm, e, g);
        end
    endtask

    task automatic check_rng(input string nm, input int lo, input int hi, input int n);
        cmp_count++;
        if (n < lo || n > hi)
        begin
            errors++;
            $display("[FAIL] %s expected %0d..%0d got %0d", nm, lo, hi, n);
        end
    endtask

    ////////////////////////////////////////
    // Port tasks; each starts and ends on a rising edge
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        cfg_wr    <= 1'h1;
        cfg_idx   <= idx;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [2:0] idx, input logic [7:0] e);
        cfg_idx <= idx;
        repeat (2) @(posedge clk_sys);
        #1;
        check("cfg_rdata", e, rdata);
        @(posedge clk_sys);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return tx_en;
            1: return rx_smp;
            default: return disc;
        endcase
    endfunction

    // Edges until the chosen output is high, bounded by the upper limit
    task automatic span(input int w, input int lo, input int hi, input string nm);
        int n;
        n = 0;
        while (pick(w) !== 1'h1 && n <= hi)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check_rng(nm, lo, hi, n);
        @(posedge clk_sys);
    endtask

    task automatic tx_run(input logic tw, input logic use_c, input logic [7:0] lag, input int lo, input int hi);
        two_w   <= tw;
        cts_use <= use_c;
        cts_lag <= lag;
        rts_req <= 1'h1;
        span(0, lo, hi, "tx_enable");
        check("rts", 8'h01, {7'h00, rts});
        rts_req <= 1'h0;
        repeat (3) @(posedge clk_sys);
        check("tx_drop", 8'h00, {7'h00, tx_en});
        repeat (30) @(posedge clk_sys);
    endtask

    task automatic rx_run(input logic tw, input int lo, input int hi);
        cts_use <= 1'h0;
        two_w   <= tw;
        rts_req <= 1'h1;
        repeat (3) @(posedge clk_sys);
        check("rx_blocked", 8'h00, {7'h00, rx_smp});
        rts_req <= 1'h0;
        span(1, lo, hi, "rx_sample");
    endtask

    task automatic dial(input int lo, input int hi);
        dial_go <= 1'h1;
        @(posedge clk_sys);
        dial_go <= 1'h0;
        span(2, lo, hi, "disconnect");
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [7:0] rst_v [8];
        rst_v = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h07, 8'h01, 8'h01, 8'h00};
        repeat (6) @(posedge clk_sys);
        reset <= 1'h0;
        span(1, TT, TT + 3, "rx_after_reset");
        for (int i = 0; i < 8; i++)
            rd(3'(i), rst_v[i]);
        check("lang_reset", 8'h00, {7'h00, lang});
        for (int i = 0; i < 8; i++)
        begin
            wr(3'(i), 8'h5A ^ 8'(i));
            rd(3'(i), 8'h5A ^ 8'(i));
        end
        check("lang_basic", 8'h01, {7'h00, lang});
        check("param", 8'h59, param);
        // Every own-rate, source and downstream combination
        for (int i = 0; i < 8; i++)
        begin
            wr(`MLTC_IDX_RATE, {6'h00, i[1], i[0]});
            ds_low <= i[2];
            repeat (4) @(posedge clk_sys);
            check("line_rate", {7'h00, i[1] ? i[0] : i[2]}, {7'h00, rate_low});
        end
        // Lone terminal imposes its own rate; all timing loaded before use
        wr(`MLTC_IDX_RATE, 8'h02);
        wr(`MLTC_IDX_FW_TX, 8'h02);
        wr(`MLTC_IDX_TW_TX, 8'h06);
        wr(`MLTC_IDX_FW_RX, 8'h05);
        wr(`MLTC_IDX_TW_RX, 8'h02);
        wr(`MLTC_IDX_RING, 8'h03);
        tx_run(1'h0, 1'h1, 8'h00, 2 * TT + 1, 2 * TT + 4);
        tx_run(1'h1, 1'h1, 8'h00, 6 * TT + 1, 6 * TT + 4);
        tx_run(1'h0, 1'h0, 8'h00, 1, 2);
        tx_run(1'h1, 1'h0, 8'h00, 1, 2);
        tx_run(1'h0, 1'h1, 8'h28, 41, 46);
        wr(`MLTC_IDX_FW_TX, 8'hFF);
        tx_run(1'h0, 1'h1, 8'h00, 144 * TT + 1, 144 * TT + 4);
        wr(`MLTC_IDX_FW_TX, 8'h00);
        tx_run(1'h0, 1'h1, 8'h00, 1, 4);
        rx_run(1'h0, 5 * TT + 1, 5 * TT + 4);
        rx_run(1'h1, 2 * TT + 1, 2 * TT + 4);
        dial(3 * RT, 3 * RT + 4);
        ans_en <= 1'h1;
        dial_go <= 1'h1;
        @(posedge clk_sys);
        dial_go <= 1'h0;
        repeat (50) @(posedge clk_sys);
        check("answered", 8'h00, {7'h00, disc});
        ans_en <= 1'h0;
        wr(`MLTC_IDX_RING, 8'h00);
        dial(1, 3);
        summarize();
    end
endmodule

// File: pkg/mltc_map.svh
// Register indexes, field positions, reset values and timing figures
// Assumes: included by bare name from the package and from the bench
`ifndef MLTC_MAP_SVH
`define MLTC_MAP_SVH

// Register indexes on the load port
`define MLTC_IDX_RATE     3'h0
`define MLTC_IDX_FW_RX    3'h1
`define MLTC_IDX_FW_TX    3'h2
`define MLTC_IDX_PARAM    3'h3
`define MLTC_IDX_RING     3'h4
`define MLTC_IDX_TW_RX    3'h5
`define MLTC_IDX_TW_TX    3'h6
`define MLTC_IDX_MODE     3'h7

// Field positions
`define MLTC_BIT_OWN_RATE 0
`define MLTC_BIT_RATE_SRC 1
`define MLTC_BIT_LANG     0

// Reset values
`define MLTC_RST_RATE     8'h00
`define MLTC_RST_TURN     8'h01
`define MLTC_RST_PARAM    8'h00
`define MLTC_RST_RING     8'h07
`define MLTC_RST_MODE     8'h00

// Largest valid turnaround count
`define MLTC_TURN_MAX     8'h90

// Timing figures
`define MLTC_CLK_NS       50
`define MLTC_TURN_TICK_NS 1750000
`define MLTC_RING_TICK_S  6
`define MLTC_NS_PER_S     1000000000
`define MLTC_TURN_PRE_W   16
`define MLTC_RING_PRE_W   27

`endif

// File: pkg/mltc_pkg.sv
// Types shared by the line timing block
// Assumes: the map header sits on the include path
package mltc_pkg;
    `include "mltc_map.svh"

    // Turnaround sequencer states
    typedef enum logic [2:0]
    {
        MLTC_RX_DLY,
        MLTC_RX,
        MLTC_TX_DLY,
        MLTC_TX_CTS,
        MLTC_TX
    } mltc_line_t;

    // Language values of the mode register
    typedef enum logic
    {
        MLTC_EXTENDED_VM_LANGUAGE,
        MLTC_BASIC_VM_LANGUAGE
    } mltc_lang_t;
endpackage

// File: src/mltc_line_timing.sv
// Line rate selection, modem turnaround timing, ring limit and parameter byte
// Assumes: inputs synchronous to clk_sys, host loads registers before use
//
// How it works
// RULE1: Mode bit 0 selects the extended language and 1 the basic one, 0 after reset.
// RULE2: Own-rate bit 0 means high rate and 1 the fall-back rate, 0 after reset.
// RULE3: The own-rate bit matters only while the rate-source bit is 1.
// RULE4: Rate-source 0 follows the downstream rate input, 1 imposes the own rate.
// RULE5: The farthest or lone terminal should impose the rate, nearer ones follow.
// RULE6: Turnaround counts are 8-bit tick counts of 1.75 ms, valid from 0x00 to 0x90.
// RULE7: In four-wire mode the four-wire receive delay runs before receive sampling.
// RULE8: After raising request-to-send the transmit delay runs, then clear-to-send gates transmit.
// RULE9: The four-wire transmit delay is used only with line type 0 and clear-to-send use 1.
// RULE10: In two-wire mode the two-wire receive delay runs before receive sampling.
// RULE11: The two-wire transmit delay is used only with line type 1 and clear-to-send use 1.
// RULE12: Both receive delays and the four-wire transmit delay reset to one tick.
// RULE13: A dial attempt waits ring count times 6 s for an answer, then disconnects.
// RULE14: The ring count resets to 0x07, a 42 s wait.
// RULE15: The 8-bit parameter byte resets to 0 and passes unchanged to the procedure.
// RULE16: The host loads rates, delays and ring limit before starting the procedure.
// RULE17: Delays count down one per derived 1.75 ms or 6 s tick until zero.
`timescale 1ns/100ps

module mltc_line_timing
    import mltc_pkg::*;
#(
    parameter int TURN_TICK_CYC = (`MLTC_TURN_TICK_NS + `MLTC_CLK_NS - 1) / `MLTC_CLK_NS,
    parameter int RING_TICK_CYC = `MLTC_RING_TICK_S * (`MLTC_NS_PER_S / `MLTC_CLK_NS)
)
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       cfg_wr,
    input  wire logic [2:0] cfg_idx,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata_ff,
    input  wire logic       line_two_wire,
    input  wire logic       cts_use,
    input  wire logic       rts_req,
    input  wire logic       cts_in,
    input  wire logic       downstream_rate_low,
    input  wire logic       dial_start,
    input  wire logic       dial_answer,
    output logic            rts_ff,
    output logic            tx_enable_ff,
    output logic            rx_sample_ff,
    output logic            line_rate_low_ff,
    output logic            dial_disconnect_ff,
    output logic            basic_vm_language_ff,
    output logic      [7:0] proc_param_ff
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [7:0] cfg_ff  [8];
    logic [7:0] nxt_cfg [8];

    // Per-entry load; write strobe selects one entry
    for (genvar gi = 0; gi < 8; gi++)
    begin : g_cfg
        always_comb
        begin
            nxt_cfg[gi] = (cfg_wr && cfg_idx == 3'(gi)) ? cfg_wdata : cfg_ff[gi];
        end

        // Reset values are constants per entry; the rest are turnaround delays
        always_ff @(posedge clk_sys or posedge reset)
        begin
            if (reset)
            begin
                if (3'(gi) == `MLTC_IDX_RING)
                    cfg_ff[gi] <= `MLTC_RST_RING;     // RULE14
                else if (3'(gi) == `MLTC_IDX_RATE)
                    cfg_ff[gi] <= `MLTC_RST_RATE;     // RULE2
                else if (3'(gi) == `MLTC_IDX_PARAM)
                    cfg_ff[gi] <= `MLTC_RST_PARAM;    // RULE15
                else if (3'(gi) == `MLTC_IDX_MODE)
                    cfg_ff[gi] <= `MLTC_RST_MODE;     // RULE1
                else
                    cfg_ff[gi] <= `MLTC_RST_TURN;     // RULE12
            end
            else
                cfg_ff[gi] <= nxt_cfg[gi];
        end
    end

    // Counts above the valid range are held at the top of the range
    function automatic logic [7:0] turn_clip(input logic [7:0] cnt);
        return (cnt > `MLTC_TURN_MAX) ? `MLTC_TURN_MAX : cnt;  // RULE6
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Turnaround sequencer

    mltc_line_t                        line_ff;
    mltc_line_t                        nxt_line;
    logic [7:0]                        turn_cnt_ff;
    logic [7:0]                        nxt_turn_cnt;
    logic [`MLTC_TURN_PRE_W-1:0]       turn_pre_ff;
    logic [`MLTC_TURN_PRE_W-1:0]       nxt_turn_pre;
    logic                              turn_tick;
    logic                              turn_load;
    logic [7:0]                        turn_value;
    logic                              nxt_rts;
    logic                              nxt_tx_enable;
    logic                              nxt_rx_sample;

    // Prescaler restarts on each load so the first tick is a full one
    assign turn_tick = (turn_pre_ff == `MLTC_TURN_PRE_W'(TURN_TICK_CYC - 1));  // RULE17

    always_comb
    begin
        nxt_line   = line_ff;
        turn_load  = 1'b0;
        turn_value = 8'h00;
        case (line_ff)
            MLTC_RX_DLY, MLTC_RX:
            begin
                if (rts_req)
                begin
                    turn_load = 1'b1;
                    // Without clear-to-send use there is no wait at all
                    if (!cts_use)
                        nxt_line = MLTC_TX;
                    else
                    begin
                        nxt_line   = MLTC_TX_DLY;                              // RULE8
                        turn_value = line_two_wire ? cfg_ff[`MLTC_IDX_TW_TX]   // RULE11
                                                   : cfg_ff[`MLTC_IDX_FW_TX];  // RULE9
                    end
                end
                else if (line_ff == MLTC_RX_DLY && turn_cnt_ff == 8'h00)
                    nxt_line = MLTC_RX;
            end
            MLTC_TX_DLY, MLTC_TX_CTS, MLTC_TX:
            begin
                if (!rts_req)
                begin
                    turn_load  = 1'b1;
                    nxt_line   = MLTC_RX_DLY;
                    turn_value = line_two_wire ? cfg_ff[`MLTC_IDX_TW_RX]       // RULE10
                                               : cfg_ff[`MLTC_IDX_FW_RX];      // RULE7
                end
                else if (line_ff == MLTC_TX_DLY && turn_cnt_ff == 8'h00)
                    nxt_line = MLTC_TX_CTS;
                else if (line_ff == MLTC_TX_CTS && cts_in)
                    nxt_line = MLTC_TX;                                        // RULE8
            end
            default:
                nxt_line = MLTC_RX_DLY;
        endcase

        // Count down once per tick, hold at zero
        if (turn_load)
        begin
            nxt_turn_cnt = turn_clip(turn_value);
            nxt_turn_pre = '0;
        end
        else
        begin
            nxt_turn_cnt = (turn_tick && turn_cnt_ff != 8'h00) ? turn_cnt_ff - 8'h01
                                                               : turn_cnt_ff;  // RULE17
            nxt_turn_pre = turn_tick ? '0 : turn_pre_ff + `MLTC_TURN_PRE_W'(1);
        end

        nxt_rts       = (nxt_line == MLTC_TX_DLY || nxt_line == MLTC_TX_CTS || nxt_line == MLTC_TX);
        nxt_tx_enable = (nxt_line == MLTC_TX);
        nxt_rx_sample = (nxt_line == MLTC_RX);
    end

    // Reset starts in receive wait with one tick, as after a turnaround
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            line_ff      <= MLTC_RX_DLY;
            turn_cnt_ff  <= `MLTC_RST_TURN;
            turn_pre_ff  <= '0;
            rts_ff       <= 1'b0;
            tx_enable_ff <= 1'b0;
            rx_sample_ff <= 1'b0;
        end
        else
        begin
            line_ff      <= nxt_line;
            turn_cnt_ff  <= nxt_turn_cnt;
            turn_pre_ff  <= nxt_turn_pre;
            rts_ff       <= nxt_rts;
            tx_enable_ff <= nxt_tx_enable;
            rx_sample_ff <= nxt_rx_sample;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ring limit timer for dial attempts

    logic                              dial_active_ff;
    logic                              nxt_dial_active;
    logic [7:0]                        ring_cnt_ff;
    logic [7:0]                        nxt_ring_cnt;
    logic [`MLTC_RING_PRE_W-1:0]       ring_pre_ff;
    logic [`MLTC_RING_PRE_W-1:0]       nxt_ring_pre;
    logic                              ring_tick;
    logic                              nxt_dial_disconnect;

    assign ring_tick = (ring_pre_ff == `MLTC_RING_PRE_W'(RING_TICK_CYC - 1));  // RULE17

    // Disconnect stays up until the next attempt starts
    always_comb
    begin
        nxt_dial_active     = dial_active_ff;
        nxt_ring_cnt        = ring_cnt_ff;
        nxt_ring_pre        = ring_tick ? '0 : ring_pre_ff + `MLTC_RING_PRE_W'(1);
        nxt_dial_disconnect = dial_disconnect_ff;
        if (dial_start)
        begin
            nxt_dial_active     = 1'b1;
            nxt_ring_cnt        = cfg_ff[`MLTC_IDX_RING];                      // RULE13
            nxt_ring_pre        = '0;
            nxt_dial_disconnect = 1'b0;
        end
        else if (dial_active_ff)
        begin
            if (dial_answer)
                nxt_dial_active = 1'b0;
            else if (ring_cnt_ff == 8'h00)
            begin
                nxt_dial_active     = 1'b0;
                nxt_dial_disconnect = 1'b1;                                    // RULE13
            end
            else if (ring_tick)
                nxt_ring_cnt = ring_cnt_ff - 8'h01;                            // RULE17
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            dial_active_ff     <= 1'b0;
            ring_cnt_ff        <= 8'h00;
            ring_pre_ff        <= '0;
            dial_disconnect_ff <= 1'b0;
        end
        else
        begin
            dial_active_ff     <= nxt_dial_active;
            ring_cnt_ff        <= nxt_ring_cnt;
            ring_pre_ff        <= nxt_ring_pre;
            dial_disconnect_ff <= nxt_dial_disconnect;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate, language, parameter and read-back outputs

    logic       nxt_rate_low;
    logic [7:0] nxt_rdata;

    // Own rate applies only in control mode, else follow downstream
    always_comb
    begin
        nxt_rate_low = cfg_ff[`MLTC_IDX_RATE][`MLTC_BIT_RATE_SRC]
                     ? cfg_ff[`MLTC_IDX_RATE][`MLTC_BIT_OWN_RATE]              // RULE3
                     : downstream_rate_low;                                    // RULE4
        nxt_rdata    = cfg_ff[cfg_idx];
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            line_rate_low_ff     <= 1'b0;
            basic_vm_language_ff <= 1'b0;
            proc_param_ff        <= 8'h00;
            cfg_rdata_ff         <= 8'h00;
        end
        else
        begin
            line_rate_low_ff     <= nxt_rate_low;                              // RULE2
            basic_vm_language_ff <= cfg_ff[`MLTC_IDX_MODE][`MLTC_BIT_LANG];    // RULE1
            proc_param_ff        <= cfg_ff[`MLTC_IDX_PARAM];                   // RULE15
            cfg_rdata_ff         <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    rate_follow_a: assert property (                                           // RULE4
        !cfg_ff[0][1] |=> line_rate_low_ff == $past(downstream_rate_low))
        else $error("rate not following downstream");

    rate_own_a: assert property (                                              // RULE3
        cfg_ff[0][1] |=> line_rate_low_ff == $past(cfg_ff[0][0]))
        else $error("own rate not applied");

    tx_after_cts_a: assert property (                                          // RULE8
        $rose(tx_enable_ff) && $past(line_ff) == MLTC_TX_CTS |-> $past(cts_in))
        else $error("transmit started without clear-to-send");

    tx_dly_zero_a: assert property (                                           // RULE8
        line_ff == MLTC_TX_CTS |-> rts_ff && !tx_enable_ff && turn_cnt_ff == 8'h00)
        else $error("clear-to-send checked before delay end");

    fw_tx_load_a: assert property (                                            // RULE9
        line_ff == MLTC_RX && rts_req && cts_use && !line_two_wire
        |=> turn_cnt_ff == turn_clip($past(cfg_ff[2])))
        else $error("four-wire transmit delay not loaded");

    tw_tx_load_a: assert property (                                            // RULE11
        line_ff == MLTC_RX && rts_req && cts_use && line_two_wire
        |=> turn_cnt_ff == turn_clip($past(cfg_ff[6])))
        else $error("two-wire transmit delay not loaded");

    rx_dly_load_a: assert property (                                           // RULE7
        line_ff == MLTC_TX && !rts_req
        |=> turn_cnt_ff == turn_clip(line_two_wire ? $past(cfg_ff[5]) : $past(cfg_ff[1])))
        else $error("receive delay not loaded");

    rx_gated_a: assert property (                                              // RULE10
        rx_sample_ff |-> line_ff == MLTC_RX && turn_cnt_ff == 8'h00 && !rts_ff)
        else $error("receive sampled during delay");

    turn_step_a: assert property (                                             // RULE17
        !turn_load && turn_cnt_ff != 8'h00 && !turn_tick |=> $stable(turn_cnt_ff))
        else $error("turnaround count moved without tick");

    ring_expire_a: assert property (                                           // RULE13
        dial_active_ff && !dial_start && !dial_answer && ring_cnt_ff == 8'h00
        |=> dial_disconnect_ff && !dial_active_ff)
        else $error("ring limit expiry not disconnecting");

    ring_answer_a: assert property (                                           // RULE13
        dial_active_ff && !dial_start && dial_answer
        |=> !dial_active_ff && !dial_disconnect_ff)
        else $error("answered attempt not ended quietly");

    param_pass_a: assert property (                                            // RULE15
        ##1 proc_param_ff == $past(cfg_ff[3]))
        else $error("parameter byte altered");
endmodule
